//--- rtl/gdfc_defines.svh
// Register offsets, field positions, reset values and fixed codes of the gate driver fault and configuration block.
`ifndef GDFC_DEFINES_SVH
`define GDFC_DEFINES_SVH
`define GDFC_ADDR_W 4
`define GDFC_OFS_THRESHOLD 4'h0
`define GDFC_OFS_CTRL 4'h1
`define GDFC_OFS_OFFSET 4'h2
`define GDFC_OFS_DESAT 4'h3
`define GDFC_OFS_FLAGS 4'h4
`define GDFC_OFS_STATUS 4'h5
`define GDFC_OFS_MASK 4'h6
`define GDFC_OFS_RELUCT 4'h7
`define GDFC_OFS_THRESHOLD_B 4'h8
`define GDFC_FLAG_LS_INT 0
`define GDFC_FLAG_LS_FLT 1
`define GDFC_FLAG_HV_INT 2
`define GDFC_FLAG_HV_FLT 3
`define GDFC_FLAG_STARTUP 4
`define GDFC_FLAG_W 5
`define GDFC_CTRL_LS_LEVEL 0
`define GDFC_RELUCT_MODE0 0
`define GDFC_RELUCT_MODE1 1
`define GDFC_DAC_BASE_V4 6'h30
`define GDFC_DAC_BASE_V56 6'h20
`define GDFC_OFFSET_STEP_MV_V4 8'h05
`define GDFC_OFFSET_STEP_MV_V56 8'h03
`define GDFC_RESET_BYTE 8'h00
`endif

//--- rtl/gdfc_pkg.sv
// Types shared by the gate driver fault and configuration block.
package gdfc_pkg;
  typedef struct packed {
    logic ls_fault;
    logic ls_status;
    logic hv_fault;
    logic hv_status;
  } gdfc_mon_s;
  typedef struct packed {
    logic [5:0] dac_a;
    logic [5:0] dac_b;
  } gdfc_dac_s;
  typedef enum logic [1:0] {
    GDFC_IN_RESET = 2'b00,
    GDFC_LOAD = 2'b01,
    GDFC_RUN = 2'b11
  } gdfc_boot_e;
endpackage : gdfc_pkg

//--- rtl/gdfc_core.sv
// Control, configuration and fault flag logic of the gate driver.
//
// Operation
// - Threshold DAC code six bits, top bit one (top two in version four)
// - Version four 48 plus field, else 32
// - Level select bit; version four forces high
// - Three-bit offset per amplifier, 5/3 mV step
// - Desat filters only in versions five, six
// - Version four: interrupt flag drives fault three
// - Versions five, six: fault flag drives three
// - Low supply fault flag clears on one
// - Version four: high voltage interrupt drives four
// - Versions five, six: fault flag drives four
// - Version four: startup flag set after reset
// - Versions five, six: startup from option bit
// - Startup flag clears on write one
// - Reluctance bit one routes desat comparator
// - Reluctance register only version six, resets zero
`timescale 1ns/10ps
`include "gdfc_defines.svh"
module gdfc_core
  import gdfc_pkg::*;
#(
  parameter int VERSION = 6
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [`GDFC_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire gdfc_mon_s MON,
  input wire logic NV_STARTUP_OPTION,
  output gdfc_dac_s DAC,
  output logic LS_LEVEL_HIGH,
  output logic [2:0] OFFSET_A,
  output logic [2:0] OFFSET_B,
  output logic [7:0] OFFSET_STEP_MV,
  output logic [1:0] DESAT_FILT_LS,
  output logic [1:0] DESAT_FILT_HS,
  output logic DESAT_ON_HIGH_SIDE,
  output logic RELUCT_MODE0,
  output logic FAULT3,
  output logic FAULT4,
  output logic IRQ
);
  localparam logic V4 = (VERSION == 4);
  localparam logic V6 = (VERSION == 6);
  localparam int TW = V4 ? 4 : 5;
  logic [4:0] thr_a;
  logic [4:0] thr_b;
  logic ls_level;
  logic [2:0] ofs_a;
  logic [2:0] ofs_b;
  logic [1:0] dsf_ls;
  logic [1:0] dsf_hs;
  logic [1:0] reluct;
  logic [`GDFC_FLAG_W-1:0] flags;
  logic [`GDFC_FLAG_W-1:0] mask;
  logic [`GDFC_FLAG_W-1:0] w1c;
  logic [`GDFC_FLAG_W-1:0] set;
  logic [`GDFC_FLAG_W-1:0] next_flags;
  gdfc_boot_e boot;
  logic wr_sel;

  // Only the field width is stored; stray upper bits in version four are dropped at the write.
  function automatic logic [5:0] dac_code(input logic [4:0] field);
    if (V4) begin
      dac_code = `GDFC_DAC_BASE_V4 | {2'b00, field[3:0]};
    end else begin
      dac_code = `GDFC_DAC_BASE_V56 | {1'b0, field};
    end
  endfunction : dac_code

  // Version four keeps four threshold bits, so the fifth written bit is dropped there.
  function automatic logic [4:0] thr_field(input logic [7:0] d);
    thr_field = (TW == 4) ? {1'b0, d[3:0]} : d[4:0];
  endfunction : thr_field

  assign wr_sel = WR && !RD;

  // Each threshold has a register of its own, since two five-bit fields do not fit one byte.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      thr_a <= 5'h00;
      thr_b <= 5'h00;
    end else if (wr_sel) begin
      if (ADDR == `GDFC_OFS_THRESHOLD) begin
        thr_a <= thr_field(WDATA);
      end
      if (ADDR == `GDFC_OFS_THRESHOLD_B) begin
        thr_b <= thr_field(WDATA);
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ls_level <= 1'b0;
    end else if (wr_sel && ADDR == `GDFC_OFS_CTRL && !V4) begin
      ls_level <= WDATA[`GDFC_CTRL_LS_LEVEL];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ofs_a <= 3'h0;
      ofs_b <= 3'h0;
    end else if (wr_sel && ADDR == `GDFC_OFS_OFFSET) begin
      ofs_a <= WDATA[2:0];
      ofs_b <= WDATA[6:4];
    end
  end

  // Version four has no filter, so writes are discarded and the fields read zero.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dsf_ls <= 2'h0;
      dsf_hs <= 2'h0;
    end else if (wr_sel && ADDR == `GDFC_OFS_DESAT && !V4) begin
      dsf_ls <= WDATA[1:0];
      dsf_hs <= WDATA[5:4];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      reluct <= 2'h0;
    end else if (wr_sel && ADDR == `GDFC_OFS_RELUCT && V6) begin
      reluct <= WDATA[1:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mask <= '0;
    end else if (wr_sel && ADDR == `GDFC_OFS_MASK) begin
      mask <= WDATA[`GDFC_FLAG_W-1:0];
    end
  end

  // Startup flag is loaded one cycle after reset release, from a clocked process.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      boot <= GDFC_IN_RESET;
    end else begin
      unique case (boot)
        GDFC_IN_RESET: boot <= GDFC_LOAD;
        GDFC_LOAD: boot <= GDFC_RUN;
        GDFC_RUN: boot <= GDFC_RUN;
        default: boot <= GDFC_RUN;
      endcase
    end
  end

  always_comb begin
    w1c = (wr_sel && ADDR == `GDFC_OFS_FLAGS) ? WDATA[`GDFC_FLAG_W-1:0] : '0;
    set = '0;
    set[`GDFC_FLAG_LS_FLT] = MON.ls_fault;
    set[`GDFC_FLAG_HV_FLT] = MON.hv_fault;
    set[`GDFC_FLAG_LS_INT] = MON.ls_fault || !MON.ls_status;
    set[`GDFC_FLAG_HV_INT] = MON.hv_fault || !MON.hv_status;
    if (boot == GDFC_IN_RESET) begin
      set[`GDFC_FLAG_STARTUP] = V4 ? 1'b1 : !NV_STARTUP_OPTION;
    end
    next_flags = (flags & ~w1c) | set;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FAULT3 <= 1'b0;
      FAULT4 <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      FAULT3 <= V4 ? next_flags[`GDFC_FLAG_LS_INT] : next_flags[`GDFC_FLAG_LS_FLT];
      FAULT4 <= V4 ? next_flags[`GDFC_FLAG_HV_INT] : next_flags[`GDFC_FLAG_HV_FLT];
      IRQ <= |(next_flags & mask);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DAC <= '0;
      LS_LEVEL_HIGH <= 1'b0;
      OFFSET_A <= 3'h0;
      OFFSET_B <= 3'h0;
      OFFSET_STEP_MV <= `GDFC_RESET_BYTE;
      DESAT_FILT_LS <= 2'h0;
      DESAT_FILT_HS <= 2'h0;
      DESAT_ON_HIGH_SIDE <= 1'b1;
      RELUCT_MODE0 <= 1'b0;
    end else begin
      DAC.dac_a <= dac_code(thr_a);
      DAC.dac_b <= dac_code(thr_b);
      LS_LEVEL_HIGH <= V4 ? 1'b1 : ls_level;
      OFFSET_A <= ofs_a;
      OFFSET_B <= ofs_b;
      OFFSET_STEP_MV <= V4 ? `GDFC_OFFSET_STEP_MV_V4 : `GDFC_OFFSET_STEP_MV_V56;
      DESAT_FILT_LS <= dsf_ls;
      DESAT_FILT_HS <= dsf_hs;
      DESAT_ON_HIGH_SIDE <= !reluct[`GDFC_RELUCT_MODE1];
      RELUCT_MODE0 <= reluct[`GDFC_RELUCT_MODE0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA <= `GDFC_RESET_BYTE;
    end else if (RD) begin
      unique case (ADDR)
        `GDFC_OFS_THRESHOLD: RDATA <= {3'h0, thr_a};
        `GDFC_OFS_THRESHOLD_B: RDATA <= {3'h0, thr_b};
        `GDFC_OFS_CTRL: RDATA <= {7'h00, V4 ? 1'b1 : ls_level};
        `GDFC_OFS_OFFSET: RDATA <= {1'b0, ofs_b, 1'b0, ofs_a};
        `GDFC_OFS_DESAT: RDATA <= {2'h0, dsf_hs, 2'h0, dsf_ls};
        `GDFC_OFS_FLAGS: RDATA <= {3'h0, flags};
        `GDFC_OFS_STATUS: RDATA <= {4'h0, MON.hv_status, MON.hv_fault, MON.ls_status, MON.ls_fault};
        `GDFC_OFS_MASK: RDATA <= {3'h0, mask};
        `GDFC_OFS_RELUCT: RDATA <= {6'h00, reluct};
        default: RDATA <= `GDFC_RESET_BYTE;
      endcase
    end else begin
      RDATA <= `GDFC_RESET_BYTE;
    end
  end
endmodule : gdfc_core

//--- verif/gdfc_checker.sv
// Port assertions of the gate driver fault and configuration block.
`timescale 1ns/10ps
module gdfc_checker
  import gdfc_pkg::*;
#(
  parameter int VERSION = 6
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire gdfc_mon_s MON,
  input wire gdfc_dac_s DAC,
  input wire logic LS_LEVEL_HIGH,
  input wire logic [7:0] OFFSET_STEP_MV,
  input wire logic DESAT_ON_HIGH_SIDE,
  input wire logic FAULT3,
  input wire logic FAULT4,
  input wire logic IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_dac_base: assert property (!$past(RST) |-> DAC.dac_a[5] && DAC.dac_b[5] &&
    (VERSION != 4 || (DAC.dac_a[4] && DAC.dac_b[4]))) else $error("dac base");
  chk_step_size: assert property (!$past(RST) |->
    OFFSET_STEP_MV == ((VERSION == 4) ? 8'h05 : 8'h03)) else $error("offset step");
  chk_ls_fault: assert property (MON.ls_fault |=> FAULT3) else $error("fault3 late");
  chk_hv_fault: assert property (MON.hv_fault |=> FAULT4) else $error("fault4 late");
  chk_fault3_clear: assert property (VERSION != 4 && $fell(FAULT3) |->
    $past(WR && ADDR == 4'h4 && WDATA[1])) else $error("fault3 fell");
  chk_fault4_clear: assert property (VERSION != 4 && $fell(FAULT4) |->
    $past(WR && ADDR == 4'h4 && WDATA[3])) else $error("fault4 fell");
  chk_desat_route: assert property (WR && ADDR == 4'h7 |-> ##2
    DESAT_ON_HIGH_SIDE == (VERSION != 6 || !$past(WDATA[1], 2))) else $error("desat route");
  chk_level_sel: assert property (WR && ADDR == 4'h1 |-> ##2
    LS_LEVEL_HIGH == (VERSION == 4 || $past(WDATA[0], 2))) else $error("level select");
  cover property ($rose(FAULT3));
  cover property ($rose(FAULT4));
  cover property ($rose(IRQ));
endmodule : gdfc_checker
bind gdfc_core gdfc_checker #(.VERSION(VERSION)) gdfc_checker_inst (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .MON(MON), .DAC(DAC), .LS_LEVEL_HIGH(LS_LEVEL_HIGH), .OFFSET_STEP_MV(OFFSET_STEP_MV),
  .DESAT_ON_HIGH_SIDE(DESAT_ON_HIGH_SIDE), .FAULT3(FAULT3), .FAULT4(FAULT4), .IRQ(IRQ));

//--- verif/gdfc_pwm_model.sv
// Model of the fault inputs of the pulse width modulator.
`timescale 1ns/10ps
module gdfc_pwm_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fault3,
  input wire logic fault4,
  output logic [1:0] seen
);
  // Faults latch until reset, so a one-cycle pulse is never missed.
  always_ff @(posedge clk_sys) begin
    if (rst) seen <= 2'b00;
    else seen <= seen | {fault4, fault3};
  end
endmodule : gdfc_pwm_model

//--- verif/gdfc_core_tb.sv
// Testbench of the gate driver fault and configuration block.
`timescale 1ns/10ps
module gdfc_core_tb;
  import gdfc_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, nv = 0, lvl, mode0, hs, f3, f4, irq;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, step;
  logic [2:0] oa, ob;
  logic [1:0] fl, fh, seen;
  gdfc_mon_s mon = 4'b0101;
  gdfc_dac_s dac;
  logic lvl4, mode0_4, hs4, f3_4, f4_4;
  logic [7:0] rdata4, step4;
  logic [1:0] fl4, fh4;
  gdfc_dac_s dac4;
  int n_errors = 0, checked = 0;
  always #20 clk = ~clk;
  gdfc_core #(.VERSION(6)) gdfc_core_inst (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .MON(mon), .NV_STARTUP_OPTION(nv), .DAC(dac), .LS_LEVEL_HIGH(lvl),
    .OFFSET_A(oa), .OFFSET_B(ob), .OFFSET_STEP_MV(step), .DESAT_FILT_LS(fl), .DESAT_FILT_HS(fh),
    .DESAT_ON_HIGH_SIDE(hs), .RELUCT_MODE0(mode0), .FAULT3(f3), .FAULT4(f4), .IRQ(irq));
  gdfc_core #(.VERSION(4)) gdfc_core_v4_inst (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata4), .MON(mon), .NV_STARTUP_OPTION(nv), .DAC(dac4), .LS_LEVEL_HIGH(lvl4),
    .OFFSET_A(), .OFFSET_B(), .OFFSET_STEP_MV(step4), .DESAT_FILT_LS(fl4), .DESAT_FILT_HS(fh4),
    .DESAT_ON_HIGH_SIDE(hs4), .RELUCT_MODE0(mode0_4), .FAULT3(f3_4), .FAULT4(f4_4), .IRQ());
  gdfc_pwm_model gdfc_pwm_model_inst (.clk_sys(clk), .rst(rst), .fault3(f3), .fault4(f4), .seen(seen));
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic bw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    // Outputs are registered behind the written registers, so they settle one edge later.
    @(posedge clk);
    #1;
  endtask : bw
  task automatic br(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1;
    cmp(12'(rdata), 12'(e));
  endtask : br
  task automatic do_reset(input logic opt);
    @(posedge clk);
    nv <= opt;
    rst <= 1;
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
  endtask : do_reset
  task automatic t_fault(input gdfc_mon_s m, input logic [7:0] f);
    @(posedge clk);
    mon <= m;
    @(posedge clk);
    mon <= 4'b0101;
    br(4'h4, f);
    bw(4'h4, f & 8'h05);
    cmp(12'({f4_4, f3_4, f4, f3}), 12'({2'b00, f[3], f[1]}));
    bw(4'h4, f & 8'h0a);
    cmp(12'({f4, f3}), 12'h000);
  endtask : t_fault
  task automatic test_done;
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    do_reset(0);
    cmp(dac, 12'h820);
    cmp(dac4, 12'hc30);
    cmp(12'({step, 3'h0, hs}), 12'h031);
    cmp(12'(step4), 12'h005);
    br(4'h7, 8'h00);
    br(4'hf, 8'h00);
    br(4'h4, 8'h10);
    cmp(12'(rdata4), 12'h010);
    bw(4'h4, 8'h10);
    br(4'h4, 8'h00);
    bw(4'h0, 8'h0f);
    bw(4'h8, 8'h15);
    cmp(dac, 12'hbf5);
    cmp(dac4, 12'hff5);
    br(4'h8, 8'h15);
    bw(4'h2, 8'h75);
    cmp(12'({oa, ob}), 12'h02f);
    bw(4'h3, 8'h31);
    cmp(12'({fl4, fh4, fl, fh}), 12'h007);
    bw(4'h1, 8'h01);
    cmp(12'({lvl4, lvl}), 12'h003);
    t_fault(4'b1101, 8'h03);
    t_fault(4'b0111, 8'h0c);
    // A supply dip alone sets only the interrupt flag, so fault three stays low in version six but rises in version four.
    bw(4'h6, 8'h01);
    @(posedge clk);
    mon <= 4'b0001;
    @(posedge clk);
    mon <= 4'b0101;
    repeat (2) @(posedge clk);
    #1;
    cmp(12'({f3_4, f3, irq}), 12'h005);
    bw(4'h6, 8'h00);
    @(posedge clk);
    #1;
    cmp(12'(irq), 12'h000);
    bw(4'h4, 8'h01);
    bw(4'h7, 8'h03);
    cmp(12'({mode0_4, hs4, mode0, hs}), 12'h006);
    br(4'h7, 8'h03);
    cmp(12'(seen), 12'h003);
    do_reset(1);
    br(4'h4, 8'h00);
    cmp(12'(rdata4), 12'h010);
    cmp(12'({mode0_4, hs4, mode0, hs}), 12'h005);
    test_done;
  end
endmodule : gdfc_core_tb
